// [inc/frt_consts.vh]
`ifndef FRT_CONSTS_VH
`define FRT_CONSTS_VH

// Core clock period and the microsecond time base.
`define FRT_CLK_PERIOD_NS 8
`define FRT_US_NS 1000
`define FRT_US_CYCLES ((`FRT_US_NS + `FRT_CLK_PERIOD_NS - 1) / `FRT_CLK_PERIOD_NS)

// Periodic output: 1.024 ms expressed in microsecond counts.
`define FRT_MS_US 1024

// Reset values.
`define FRT_CNT_RST 16'h0000
`define FRT_CAP_RST 8'h00
`define FRT_PIT_RST 16'h0000
`define FRT_WAKE_RST 8'h00

// Capture slice selection: lowest bit of the 8-bit slice, 0 to 8.
`define FRT_SLICE_MAX 4'h8

// Capture pin synchroniser length.
`define FRT_SYNC_LEN 3

`endif

// [hw/frt_timer.v]
// What this block does
// - A 16-bit counter runs as the common time base and holds its value during suspend.
// - Interval timer with 1 us resolution raises an interrupt when it expires.
// - A periodic interrupt fires every 1.024 ms from the counter.
// - A wrap interrupt fires when the counter rolls from maximum to zero.
// - A selected edge on a capture pin stores an 8-bit counter slice.
// - The two capture channels can be ganged into one 16-bit capture.
// - A capture interrupt fires whenever a selected edge stores a new value.
// - Each capture pin has separate rising-edge and falling-edge registers.
// - Firmware can read the running counter to time events by difference.
// - A low-power wake-up timer keeps running during suspend.
// - When enabled, the wake-up timer raises periodic interrupts.

`include "frt_consts.vh"

module frt_cap_chan (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Capture pin, raw from outside
  input wire pin_i,
  // Value to store and edge source
  input wire [7:0] data_i,
  input wire use_ext_i,
  input wire ext_rise_i,
  input wire ext_fall_i,
  // Configuration
  input wire rise_en_i,
  input wire fall_en_i,
  input wire irq_en_i,
  // Own edges, for ganging
  output wire rise_o,
  output wire fall_o,
  // Captured values and interrupt
  output reg [7:0] rise_cap_o,
  output reg [7:0] fall_cap_o,
  output reg irq_o
);

  reg [`FRT_SYNC_LEN-1:0] sync;
  reg level;
  wire settled;
  wire take_rise;
  wire take_fall;

  // The first stage may be metastable, so it is never looked at. A change only
  // counts once the second and third stages agree, which also drops a pin
  // glitch that lasts a single clock.
  assign settled = (sync[1] == sync[2]);
  assign rise_o = settled & sync[2] & ~level;
  assign fall_o = settled & ~sync[2] & level;
  assign take_rise = rise_en_i & (use_ext_i ? ext_rise_i : rise_o);
  assign take_fall = fall_en_i & (use_ext_i ? ext_fall_i : fall_o);

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      sync <= {`FRT_SYNC_LEN{1'b0}};
      level <= 1'b0;
      rise_cap_o <= `FRT_CAP_RST;
      fall_cap_o <= `FRT_CAP_RST;
      irq_o <= 1'b0;
    end else begin
      sync <= {sync[`FRT_SYNC_LEN-2:0], pin_i};
      if (settled) begin
        level <= sync[2];
      end
      if (take_rise) begin
        rise_cap_o <= data_i;
      end
      if (take_fall) begin
        fall_cap_o <= data_i;
      end
      irq_o <= irq_en_i & (take_rise | take_fall);
    end
  end

endmodule // frt_cap_chan

module frt_timer (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Power state
  input wire suspend_i,
  // Capture pins
  input wire capture_input_zero,
  input wire capture_input_one,
  // Capture configuration
  input wire [3:0] slice_sel_i,
  input wire gang_en_i,
  input wire cap0_rise_en_i,
  input wire cap0_fall_en_i,
  input wire cap1_rise_en_i,
  input wire cap1_fall_en_i,
  input wire cap0_irq_en_i,
  input wire cap1_irq_en_i,
  // Interval timer configuration
  input wire pit_en_i,
  input wire [15:0] pit_reload_i,
  // Wake-up timer configuration
  input wire wake_en_i,
  input wire [7:0] wake_period_i,
  // Counter read-out
  input wire snap_req_i,
  output reg [15:0] count_o,
  output reg [15:0] snap_o,
  // Captured values
  output wire [7:0] cap0_rise_o,
  output wire [7:0] cap0_fall_o,
  output wire [7:0] cap1_rise_o,
  output wire [7:0] cap1_fall_o,
  // Interrupt requests, one-cycle pulses
  output reg pit_irq_o,
  output reg ms_irq_o,
  output reg wrap_irq_o,
  output wire cap0_irq_o,
  output wire cap1_irq_o,
  output reg wake_irq_o
);

  localparam integer PRESC_CYCLES = `FRT_US_CYCLES - 1;
  localparam integer MS_COUNTS = `FRT_MS_US - 1;
  localparam [6:0] PRESC_LAST = PRESC_CYCLES[6:0];
  localparam [9:0] MS_LAST = MS_COUNTS[9:0];

  // Interval timer states.
  localparam [2:0] PIT_IDLE = 3'h1;
  localparam [2:0] PIT_LOAD = 3'h2;
  localparam [2:0] PIT_RUN = 3'h4;

  reg [6:0] presc;
  reg us_tick;
  reg [2:0] pit_state;
  reg [2:0] next_pit_state;
  reg [15:0] pit_cnt;
  reg [6:0] wake_presc;
  reg [9:0] wake_us;
  reg [7:0] wake_cnt;
  reg [3:0] sel;
  wire [15:0] shifted;
  wire [7:0] slice;
  wire [7:0] data0;
  wire [7:0] data1;
  wire rise0;
  wire fall0;
  wire wake_ms;
  wire [7:0] wake_last;

  // Main microsecond prescaler. It halts in suspend to save power, which is
  // why the wake-up timer keeps a prescaler of its own.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      presc <= 7'h00;
      us_tick <= 1'b0;
    end else if (suspend_i) begin
      us_tick <= 1'b0;
    end else if (presc == PRESC_LAST) begin
      presc <= 7'h00;
      us_tick <= 1'b1;
    end else begin
      presc <= presc + 7'h01;
      us_tick <= 1'b0;
    end
  end

  // Free-running count, periodic and wrap events.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      count_o <= `FRT_CNT_RST;
      ms_irq_o <= 1'b0;
      wrap_irq_o <= 1'b0;
    end else begin
      ms_irq_o <= 1'b0;
      wrap_irq_o <= 1'b0;
      if (us_tick) begin
        count_o <= count_o + 16'h0001;
        ms_irq_o <= (count_o[9:0] == MS_LAST);
        wrap_irq_o <= (count_o == 16'hFFFF);
      end
    end
  end

  // A snapshot lets narrow software reads see both bytes from one instant.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      snap_o <= `FRT_CNT_RST;
    end else if (snap_req_i) begin
      snap_o <= count_o;
    end
  end

  // Interval timer: loads on enable, counts microseconds down, fires at zero
  // and reloads, so the interval is reload plus one microsecond.
  // Clearing the enable silences the pulse at once rather than one edge later.
  always @* begin
    case (pit_state)
      PIT_IDLE: begin
        next_pit_state = pit_en_i ? PIT_LOAD : PIT_IDLE;
      end
      PIT_LOAD: begin
        next_pit_state = pit_en_i ? PIT_RUN : PIT_IDLE;
      end
      PIT_RUN: begin
        next_pit_state = pit_en_i ? PIT_RUN : PIT_IDLE;
      end
      default: begin
        next_pit_state = PIT_IDLE;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      pit_state <= PIT_IDLE;
      pit_cnt <= `FRT_PIT_RST;
      pit_irq_o <= 1'b0;
    end else begin
      pit_state <= next_pit_state;
      pit_irq_o <= 1'b0;
      if (pit_state == PIT_LOAD) begin
        pit_cnt <= pit_reload_i;
      end else if (pit_state == PIT_RUN && pit_en_i && us_tick) begin
        if (pit_cnt == 16'h0000) begin
          pit_cnt <= pit_reload_i;
          pit_irq_o <= 1'b1;
        end else begin
          pit_cnt <= pit_cnt - 16'h0001;
        end
      end
    end
  end

  // Capture slice position, clamped so the slice stays inside 16 bits.
  always @* begin
    if (slice_sel_i > `FRT_SLICE_MAX) begin
      sel = `FRT_SLICE_MAX;
    end else begin
      sel = slice_sel_i;
    end
  end

  assign shifted = count_o >> sel;
  assign slice = shifted[7:0];
  assign data0 = gang_en_i ? count_o[7:0] : slice;
  assign data1 = gang_en_i ? count_o[15:8] : slice;

  frt_cap_chan u_cap0 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(capture_input_zero),
    .data_i(data0),
    .use_ext_i(1'b0),
    .ext_rise_i(1'b0),
    .ext_fall_i(1'b0),
    .rise_en_i(cap0_rise_en_i),
    .fall_en_i(cap0_fall_en_i),
    .irq_en_i(cap0_irq_en_i),
    .rise_o(rise0),
    .fall_o(fall0),
    .rise_cap_o(cap0_rise_o),
    .fall_cap_o(cap0_fall_o),
    .irq_o(cap0_irq_o)
  );

  // Ganged, channel one follows channel zero's pin and edge enables and keeps
  // its interrupt quiet so that one 16-bit capture gives one interrupt.
  frt_cap_chan u_cap1 (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i(capture_input_one),
    .data_i(data1),
    .use_ext_i(gang_en_i),
    .ext_rise_i(rise0),
    .ext_fall_i(fall0),
    .rise_en_i(gang_en_i ? cap0_rise_en_i : cap1_rise_en_i),
    .fall_en_i(gang_en_i ? cap0_fall_en_i : cap1_fall_en_i),
    .irq_en_i(cap1_irq_en_i & ~gang_en_i),
    .rise_o(),
    .fall_o(),
    .rise_cap_o(cap1_rise_o),
    .fall_cap_o(cap1_fall_o),
    .irq_o(cap1_irq_o)
  );

  // Wake-up timer on its own prescaler; suspend does not stop it.
  assign wake_ms = (wake_presc == PRESC_LAST) && (wake_us == MS_LAST);
  assign wake_last = (wake_period_i == 8'h00) ? 8'h00 : wake_period_i - 8'h01;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      wake_presc <= 7'h00;
      wake_us <= 10'h000;
      wake_cnt <= `FRT_WAKE_RST;
      wake_irq_o <= 1'b0;
    end else if (!wake_en_i) begin
      wake_presc <= 7'h00;
      wake_us <= 10'h000;
      wake_cnt <= `FRT_WAKE_RST;
      wake_irq_o <= 1'b0;
    end else begin
      wake_irq_o <= 1'b0;
      if (wake_presc == PRESC_LAST) begin
        wake_presc <= 7'h00;
        wake_us <= (wake_us == MS_LAST) ? 10'h000 : wake_us + 10'h001;
      end else begin
        wake_presc <= wake_presc + 7'h01;
      end
      if (wake_ms) begin
        if (wake_cnt >= wake_last) begin
          wake_cnt <= `FRT_WAKE_RST;
          wake_irq_o <= 1'b1;
        end else begin
          wake_cnt <= wake_cnt + 8'h01;
        end
      end
    end
  end

endmodule // frt_timer

// [verification/frt_timer_assertions.sv]
module frt_timer_chk (
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Controls
  input wire suspend_i,
  input wire gang_en_i,
  input wire cap0_irq_en_i,
  input wire cap1_irq_en_i,
  input wire pit_en_i,
  input wire wake_en_i,
  input wire snap_req_i,
  // Results
  input wire [15:0] count_o,
  input wire [15:0] snap_o,
  input wire pit_irq_o,
  input wire ms_irq_o,
  input wire wrap_irq_o,
  input wire cap0_irq_o,
  input wire cap1_irq_o,
  input wire wake_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_halted;
    suspend_i ##1 suspend_i;
  endsequence
  a_count_step: assert property (
    !$past(srst_i) && $changed(count_o) |-> count_o == $past(count_o) + 16'h0001)
    else $error("count did not step by one");
  a_count_hold: assert property (
    $changed(count_o) |=> $stable(count_o) [*8]) else $error("count stepped too soon");
  a_ms_on_step: assert property (
    ms_irq_o |-> count_o[9:0] == 10'h000 && $changed(count_o) ##1 !ms_irq_o)
    else $error("ms pulse off its step");
  a_wrap_at_zero: assert property (
    wrap_irq_o |-> count_o == 16'h0000 && $past(count_o) == 16'hFFFF)
    else $error("wrap pulse without rollover");
  a_snap_copy: assert property (
    snap_req_i |=> snap_o == $past(count_o)) else $error("snapshot mismatch");
  a_suspend_hold: assert property (
    s_halted |=> $stable(count_o)) else $error("count moved in suspend");
  a_pit_gated: assert property (
    pit_irq_o |-> $past(pit_en_i) ##1 !pit_irq_o [*8]) else $error("interval pulse wrong");
  a_cap_gated: assert property (
    cap0_irq_o |-> $past(cap0_irq_en_i)) else $error("capture pulse while masked");
  a_gang_quiet: assert property (
    cap1_irq_o |-> $past(cap1_irq_en_i) && !$past(gang_en_i))
    else $error("second capture pulse while ganged");
  a_wake_gated: assert property (
    wake_irq_o |-> $past(wake_en_i) ##1 !wake_irq_o) else $error("wake pulse wrong");
endmodule // frt_timer_chk

bind frt_timer frt_timer_chk u_frt_timer_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
  .suspend_i(suspend_i), .gang_en_i(gang_en_i), .cap0_irq_en_i(cap0_irq_en_i),
  .cap1_irq_en_i(cap1_irq_en_i), .pit_en_i(pit_en_i), .wake_en_i(wake_en_i),
  .snap_req_i(snap_req_i), .count_o(count_o), .snap_o(snap_o), .pit_irq_o(pit_irq_o),
  .ms_irq_o(ms_irq_o), .wrap_irq_o(wrap_irq_o), .cap0_irq_o(cap0_irq_o),
  .cap1_irq_o(cap1_irq_o), .wake_irq_o(wake_irq_o));

// [verification/frt_pin_src.sv]
module frt_pin_src (
  // Commanded levels
  input wire [1:0] lvl_i,
  // Capture pins
  output wire capture_input_zero,
  output wire capture_input_one
);
  timeunit 1ns;
  timeprecision 1ps;
  // Edges land away from the clock edge, as an unrelated source would.
  assign #3 capture_input_zero = lvl_i[0];
  assign #3 capture_input_one = lvl_i[1];
endmodule // frt_pin_src

// [verification/frt_timer_bench.sv]
`define FRT_CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end

module frt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, srst_i = 1, suspend_i = 0, gang_en_i = 0, snap_req_i = 0;
  logic pit_en_i = 0, wake_en_i = 0;
  logic [3:0] slice_sel_i = 4'h0, edge_en = 4'hF;
  logic [1:0] irq_en = 2'h3, pin = 2'h0;
  logic [15:0] pit_reload_i = 16'h0003, prev, c;
  logic [7:0] wake_period_i = 8'h01;
  wire capture_input_zero, capture_input_one;
  wire [15:0] count_o, snap_o;
  wire [7:0] cap [0:3];
  wire [5:0] irq;
  int failures = 0, tests_run = 0, n;
  initial forever #4 core_clk_i = ~core_clk_i;
  frt_pin_src u_frt_pin_src (.lvl_i(pin), .capture_input_zero(capture_input_zero),
    .capture_input_one(capture_input_one));
  frt_timer u_frt_timer (.core_clk_i(core_clk_i), .srst_i(srst_i), .suspend_i(suspend_i),
    .capture_input_zero(capture_input_zero), .capture_input_one(capture_input_one),
    .slice_sel_i(slice_sel_i), .gang_en_i(gang_en_i), .cap0_rise_en_i(edge_en[0]),
    .cap0_fall_en_i(edge_en[1]), .cap1_rise_en_i(edge_en[2]), .cap1_fall_en_i(edge_en[3]),
    .cap0_irq_en_i(irq_en[0]), .cap1_irq_en_i(irq_en[1]), .pit_en_i(pit_en_i),
    .pit_reload_i(pit_reload_i), .wake_en_i(wake_en_i), .wake_period_i(wake_period_i),
    .snap_req_i(snap_req_i), .count_o(count_o), .snap_o(snap_o), .cap0_rise_o(cap[0]),
    .cap0_fall_o(cap[1]), .cap1_rise_o(cap[2]), .cap1_fall_o(cap[3]), .pit_irq_o(irq[0]),
    .ms_irq_o(irq[1]), .wrap_irq_o(irq[2]), .cap0_irq_o(irq[3]), .cap1_irq_o(irq[4]),
    .wake_irq_o(irq[5]));

  task automatic stop_test();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask

  // Counts edges until the pulse; prev keeps the count from just before that edge.
  // Always steps at least once, so a pulse still showing from the last call is skipped.
  task automatic wait_irq(input int b, input int lim, input bit must);
    n = 0;
    do begin
      prev = count_o;
      step(1);
      n++;
    end while (irq[b] !== 1'b1 && n < lim);
    if (irq[b] !== 1'b1 && must) begin
      failures++;
      $display("CHECK FAILED irq %0d exp 1 got 0", b);
      stop_test();
    end
  endtask

  task automatic t_long();
    wake_en_i = 1;
    suspend_i = 1;
    c = count_o;
    step(400);
    `FRT_CHK("frozen count", c, count_o)
    suspend_i = 0;
    wait_irq(5, 128000, 1);
    `FRT_CHK("wake gap", 1'b1, n > 127595 && n < 127605)
    wake_en_i = 0;
    wait_irq(1, 3000, 1);
    `FRT_CHK("ms count", 16'h0400, count_o)
  endtask

  task automatic t_count();
    c = count_o;
    for (int i = 0; i < 2; i++) begin
      n = 0;
      while (count_o === c && n < 200) begin
        step(1);
        n++;
      end
      c = count_o;
    end
    `FRT_CHK("us period", 125, n)
    snap_req_i = 1;
    step(1);
    snap_req_i = 0;
    `FRT_CHK("snapshot", c, snap_o)
  endtask

  task automatic t_pit();
    pit_en_i = 1;
    wait_irq(0, 2000, 1);
    wait_irq(0, 600, 1);
    `FRT_CHK("pit period", 500, n)
    pit_en_i = 0;
    wait_irq(0, 1200, 0);
    `FRT_CHK("pit off", 1200, n)
  endtask

  task automatic t_cap();
    for (int s = 0; s < 13; s += 4) begin
      for (int ch = 0; ch < 2; ch++) begin
        slice_sel_i = s[3:0];
        pin[ch] = 1;
        wait_irq(3 + ch, 8, 1);
        `FRT_CHK("rise cap", 8'(prev >> (s > 8 ? 8 : s)), cap[2 * ch])
        pin[ch] = 0;
        wait_irq(3 + ch, 8, 1);
        `FRT_CHK("fall cap", 8'(prev >> (s > 8 ? 8 : s)), cap[2 * ch + 1])
      end
    end
    edge_en[0] = 0;
    pin[0] = 1;
    wait_irq(3, 8, 0);
    `FRT_CHK("edge off", 8, n)
    edge_en[0] = 1;
    irq_en[1] = 0;
    pin[1] = 1;
    wait_irq(4, 8, 0);
    `FRT_CHK("irq masked", 8, n)
    irq_en[1] = 1;
    pin = 2'h0;
    wait_irq(3, 8, 1);
    gang_en_i = 1;
    pin[0] = 1;
    wait_irq(3, 8, 1);
    `FRT_CHK("ganged", prev, {cap[2], cap[0]})
    c = {cap[3], cap[2]};
    pin[1] = 1;
    wait_irq(3, 8, 0);
    `FRT_CHK("pin one ignored", 8, n)
    `FRT_CHK("pin one hold", c, {cap[3], cap[2]})
  endtask

  initial begin
    step(2);
    srst_i = 0;
    t_long();
    t_count();
    t_pit();
    t_cap();
    stop_test();
  end
endmodule // frt_timer_bench
